// >>> verification/hwcfg_checker.sv
/* checker: port assertions for the low configuration fields.
   assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ns
`default_nettype none
module hwcfg_checker (
    input wire logic        SYS_CLK_IN,
    input wire logic        RST_N_IN,
    input wire logic [7:0]  WB_ADR_IN,
    input wire logic        WB_WE_IN,
    input wire logic        WB_ACK_OUT,
    input wire logic [31:0] WB_DAT_OUT,
    input wire logic        PHY_CHOICE_STRAP_IN,
    input wire logic        RX_FRAME_END_IN,
    input wire logic        RX_FRAME_DROP_OUT,
    input wire logic        RX_FRAME_KEEP_OUT,
    input wire logic        TX_LOSS_OF_SYNC_IN,
    input wire logic        TX_STALL_CLEAR_IN,
    input wire logic        BULK_OUT_STALL_OUT,
    input wire logic        PHY_INTERRUPT_PIN_IN,
    input wire logic [7:0]  MII_PIN_OE_OUT,
    input wire logic        PHY_INTERRUPT_PIN_OUT,
    input wire logic        PHY_INTERRUPT_PIN_OE_OUT,
    input wire logic        EE_WAIT_IN,
    input wire logic        EE_TIMEOUT_OUT,
    input wire logic        LITE_RESET_OUT
);
    reg [1:0] up;
    reg       strap_q;
    // strap copy taken at the same edge the block latches it
    always @(posedge SYS_CLK_IN) begin
        if (!RST_N_IN) up <= 2'h0;
        else if (up != 2'h3) up <= up + 2'h1;
        if (RST_N_IN && up == 2'h0) strap_q <= PHY_CHOICE_STRAP_IN;
    end
    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    property p_phy; WB_ACK_OUT && !WB_WE_IN && WB_ADR_IN == 8'h14
        |-> WB_DAT_OUT[2] == strap_q; endproperty
    a_phy: assert property (p_phy)
        else $error("phy bit");
    property p_ext; up == 2'h3 && strap_q
        |-> MII_PIN_OE_OUT == 8'h00 && !PHY_INTERRUPT_PIN_OE_OUT; endproperty
    a_ext: assert property (p_ext)
        else $error("pins driven");
    property p_vis; PHY_INTERRUPT_PIN_OE_OUT |-> MII_PIN_OE_OUT == 8'hff
        && PHY_INTERRUPT_PIN_OUT == $past(PHY_INTERRUPT_PIN_IN); endproperty
    a_vis: assert property (p_vis)
        else $error("pin view");
    property p_verdict; RX_FRAME_END_IN
        |=> RX_FRAME_DROP_OUT != RX_FRAME_KEEP_OUT; endproperty
    a_verdict: assert property (p_verdict)
        else $error("verdict");
    property p_sset; $rose(BULK_OUT_STALL_OUT)
        |-> $past(TX_LOSS_OF_SYNC_IN); endproperty
    a_sset: assert property (p_sset)
        else $error("stall cause");
    property p_sclr; TX_STALL_CLEAR_IN && !TX_LOSS_OF_SYNC_IN
        |=> !BULK_OUT_STALL_OUT; endproperty
    a_sclr: assert property (p_sclr)
        else $error("stall clear");
    property p_ee; $rose(EE_WAIT_IN)
        |-> ##[1:60] (EE_TIMEOUT_OUT || !EE_WAIT_IN); endproperty
    a_ee: assert property (p_ee)
        else $error("no time-out");
    property p_lite; $rose(LITE_RESET_OUT)
        |-> ##[1:20] !LITE_RESET_OUT; endproperty
    a_lite: assert property (p_lite)
        else $error("lite stuck");
    c_stall: cover property (BULK_OUT_STALL_OUT);
    c_drop: cover property (RX_FRAME_DROP_OUT);
    c_tmo: cover property (EE_TIMEOUT_OUT);
endmodule // hwcfg_checker
bind hwcfg_regs hwcfg_checker u_hwcfg_checker (.*);
`default_nettype wire

// >>> verification/testbench.sv
/* testbench: random and corner stimulus for the configuration block.
   assumes the block answers each bus cycle by itself. */
`timescale 1ns/1ns
`default_nettype none
module testbench;
    localparam int tmo_long = 50, tmo_short = 12, lite_cyc = 16;
    logic        SYS_CLK_IN, RST_N_IN, WB_WE_IN, WB_CYC_IN, WB_STB_IN;
    logic        PHY_CHOICE_STRAP_IN, RX_BYTE_VALID_IN, RX_FRAME_ERROR_IN;
    logic        PHY_INTERRUPT_PIN_IN, EE_WAIT_IN, WB_ACK_OUT;
    logic        RX_START_IN, RX_FRAME_END_IN, TX_LOSS_OF_SYNC_IN;
    logic        TX_STALL_CLEAR_IN, LITE_RESET_DONE_IN, RX_BYTE_VALID_OUT;
    logic        RX_FRAME_DROP_OUT, RX_FRAME_KEEP_OUT, RX_MULTI_FRAME_OK_OUT;
    logic        BULK_OUT_STALL_OUT, TX_MULTI_FRAME_OUT, PHY_INTERRUPT_PIN_OUT;
    logic        PHY_INTERRUPT_PIN_OE_OUT, EE_TIMEOUT_OUT, LITE_RESET_OUT;
    logic [3:0]  WB_SEL_IN;
    logic [4:0]  ev;
    logic [7:0]  WB_ADR_IN, RX_BYTE_IN, RX_BYTE_OUT, MII_SIGNALS_IN;
    logic [7:0]  GPIO_OUT_IN, GPIO_OE_IN, MII_PIN_OUT, MII_PIN_OE_OUT;
    logic [31:0] WB_DAT_IN, WB_DAT_OUT, rd, model;
    logic [7:0]  rxq[$];
    int          fail_count, compares, n, m;
    assign {RX_START_IN, RX_FRAME_END_IN, TX_LOSS_OF_SYNC_IN} = ev[4:2];
    assign {TX_STALL_CLEAR_IN, LITE_RESET_DONE_IN} = ev[1:0];
    hwcfg_regs #(.EE_TMO_LONG_CYC(tmo_long), .EE_TMO_SHORT_CYC(tmo_short),
                 .LITE_RST_CYC(lite_cyc)) DUT (.*);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge SYS_CLK_IN);
    endtask
    task automatic pulse(input int b);
        ev[b] <= 1'b1;
        tick(1);
        ev[b] <= 1'b0;
        tick(1);
    endtask
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s);
        int i;
        @(posedge SYS_CLK_IN);
        {WB_CYC_IN, WB_STB_IN, WB_WE_IN, WB_ADR_IN} <= {2'b11, we, a};
        {WB_DAT_IN, WB_SEL_IN} <= {d, s};
        for (i = 0; i < 20 && WB_ACK_OUT !== 1'b1; i++) tick(1);
        rd = WB_DAT_OUT;
        {WB_CYC_IN, WB_STB_IN} <= 2'b00;
        if (i == 20) begin
            fail_count++;
            finish_test();
        end
    endtask
    function automatic logic [31:0] wmask(input logic [3:0] s);
        return {21'h0, {3{s[1]}}, {4{s[0]}}, 4'h0};
    endfunction
    initial begin
        SYS_CLK_IN = 1'b0;
        forever #50 SYS_CLK_IN = ~SYS_CLK_IN;
    end
    initial begin
        #9000000;
        fail_count++;
        finish_test();
    end
    always @(posedge SYS_CLK_IN) begin
        if (RX_BYTE_VALID_OUT === 1'b1) rxq.push_back(RX_BYTE_OUT);
    end
    initial begin
        {RST_N_IN, WB_CYC_IN, WB_STB_IN, WB_WE_IN, WB_ADR_IN, ev} = '0;
        {WB_DAT_IN, WB_SEL_IN, PHY_CHOICE_STRAP_IN, RX_BYTE_IN} = '0;
        {RX_BYTE_VALID_IN, RX_FRAME_ERROR_IN, EE_WAIT_IN} = '0;
        {MII_SIGNALS_IN, PHY_INTERRUPT_PIN_IN, GPIO_OUT_IN, GPIO_OE_IN} = '0;
        n = $urandom(32'h63db);
        tick(1);
        for (int p = 1; p >= 0; p--) begin
            RST_N_IN <= 1'b0;
            PHY_CHOICE_STRAP_IN <= p[0];
            tick(4);
            RST_N_IN <= 1'b1;
            tick(2);
            model = 32'(p) << 2;
            wb(0, 8'h14, 0, 0);
            chk(rd, model);
            wb(0, 8'h18, 0, 0);
            chk(rd, 0);
            repeat (6) begin
                n = $urandom;
                m = $urandom;
                // lite bit kept clear so the readback stays predictable
                wb(1, 8'h14, n & ~32'h8, m[3:0]);
                model = (model & ~wmask(m[3:0])) | (n & wmask(m[3:0]));
                wb(0, 8'h14, 0, 0);
                chk(rd, model);
                chk(TX_MULTI_FRAME_OUT, model[5]);
            end
            for (int v = 1; v >= 0; v--) begin
                wb(1, 8'h14, v << 7, 4'h1);
                {MII_SIGNALS_IN, PHY_INTERRUPT_PIN_IN} <= 9'($urandom);
                {GPIO_OUT_IN, GPIO_OE_IN} <= 16'($urandom);
                tick(3);
                m = p ? 0 : v ? {8'hff, MII_SIGNALS_IN}
                              : {GPIO_OE_IN, GPIO_OUT_IN};
                rd = {MII_PIN_OE_OUT, MII_PIN_OUT};
                chk(rd, m);
            end
        end
        for (int k = 0; k < 4; k++) begin
            n = (k << 9) | (k[0] << 8) | (k[1] << 6) | (k[0] << 4);
            wb(1, 8'h14, n, 4'h3);
            rxq.delete();
            pulse(4);
            tick(k);
            m = $urandom;
            RX_BYTE_IN <= m[7:0];
            RX_BYTE_VALID_IN <= 1'b1;
            tick(1);
            RX_BYTE_VALID_IN <= 1'b0;
            tick(3);
            foreach (rxq[j])
                chk(rxq[j], j == k ? m[7:0] : 8'h00);
            chk(rxq.size(), k + 1);
            RX_FRAME_ERROR_IN <= k[0];
            pulse(3);
            chk({RX_FRAME_DROP_OUT, RX_FRAME_KEEP_OUT},
                k == 3 ? 2 : 1);
            pulse(2);
            chk(BULK_OUT_STALL_OUT, !k[0]);
            pulse(1);
            chk(BULK_OUT_STALL_OUT, 0);
            EE_WAIT_IN <= 1'b1;
            for (m = 0; m < 200 && EE_TIMEOUT_OUT !== 1'b1; m++) tick(1);
            n = k[0] ? tmo_short : tmo_long;
            chk(m >= n && m <= n + 2, 1);
            EE_WAIT_IN <= 1'b0;
            tick(2);
            chk(EE_TIMEOUT_OUT, 0);
        end
        wb(1, 8'h14, 32'h18, 4'h1);
        wb(0, 8'h14, 0, 0);
        chk(rd[3:2], 2'b10);
        pulse(0);
        wb(0, 8'h14, 0, 0);
        chk(rd[3:2], 2'b00);
        wb(1, 8'h14, 32'h18, 4'h1);
        tick(lite_cyc + 2);
        chk(LITE_RESET_OUT, 0);
        chk(RX_MULTI_FRAME_OK_OUT, 1);
        finish_test();
    end
endmodule // testbench
`default_nettype wire

// >>> verilog/hwcfg_map.vh
/*
 * register map constants for the low hardware configuration fields.
 * assumes: included by the block, a single 32-bit wishbone word register.
 */
`ifndef HWCFG_MAP_VH
`define HWCFG_MAP_VH

`define HWCFG_ADDR_HW_CONFIG     8'h14
`define HWCFG_BIT_RXOFF_HI       10
`define HWCFG_BIT_RXOFF_LO       9
`define HWCFG_BIT_STALL_DIS      8
`define HWCFG_BIT_MII_VIS        7
`define HWCFG_BIT_DISCARD        6
`define HWCFG_BIT_MULTI_FRAME    5
`define HWCFG_BIT_EE_TMO_SEL     4
`define HWCFG_BIT_LITE_RST       3
`define HWCFG_BIT_PHY_CHOICE     2
`define HWCFG_RST_RXOFF          2'h0
`define HWCFG_RST_BIT            1'h0
`define HWCFG_CLK_HZ             10000000
`define HWCFG_EE_TMO_LONG_US     30000
`define HWCFG_EE_TMO_SHORT_NS    1280
`define HWCFG_EE_TMO_LONG_CYC    (`HWCFG_EE_TMO_LONG_US * 10)
`define HWCFG_EE_TMO_SHORT_CYC   ((`HWCFG_EE_TMO_SHORT_NS * 10) / 1000)
`define HWCFG_LITE_RST_CYC       16

`endif

// >>> verilog/hwcfg_regs.v
/*
 * low fields of the hardware configuration register, with their
 * effects on receive offset, bulk-out stall, mii pin visibility, frame
 * discard, multi-frame packing, eeprom time-out and lite reset.
 * assumes: classic wishbone slave, single clock, synchronous inputs,
 * phy strap stable around reset release.
 */
// Notes on behaviour
// [RULE1] receive offset inserts zero to three bytes
// [RULE2] software keeps offset fixed after rx enable
// [RULE3] loss of sync stalls bulk-out unless disabled
// [RULE4] visibility bit drives mii pins as outputs
// [RULE5] visibility ignored with external phy
// [RULE6] visibility overrides general-purpose pin use
// [RULE7] discard bit drops errored receive frames
// [RULE8] multi-frame bit allows packing in transmit
// [RULE9] receive path always accepts multiple frames
// [RULE10] eeprom time-out 30 ms or 1.28 us; the short limit here is 12 cycles, 1.2 us at 10 MHz
// [RULE11] writing one starts lite reset
// [RULE12] lite reset spares usb controller, eeprom, phy
// [RULE13] lite reset bit self-clears when done
// [RULE14] phy choice reads 0 internal, 1 external
// [RULE15] phy choice reset value from strap
// [RULE16] writes to phy choice are ignored
`timescale 1ns/1ns
`default_nettype none
`include "hwcfg_map.vh"

module hwcfg_regs #(
    parameter EE_TMO_LONG_CYC  = `HWCFG_EE_TMO_LONG_CYC,
    parameter EE_TMO_SHORT_CYC = `HWCFG_EE_TMO_SHORT_CYC,
    parameter LITE_RST_CYC     = `HWCFG_LITE_RST_CYC
) (
    input  wire        SYS_CLK_IN,
    input  wire        RST_N_IN,
    input  wire [7:0]  WB_ADR_IN,
    input  wire [31:0] WB_DAT_IN,
    input  wire [3:0]  WB_SEL_IN,
    input  wire        WB_WE_IN,
    input  wire        WB_CYC_IN,
    input  wire        WB_STB_IN,
    output reg  [31:0] WB_DAT_OUT,
    output reg         WB_ACK_OUT,
    input  wire        PHY_CHOICE_STRAP_IN,
    input  wire        RX_START_IN,
    input  wire [7:0]  RX_BYTE_IN,
    input  wire        RX_BYTE_VALID_IN,
    output reg  [7:0]  RX_BYTE_OUT,
    output reg         RX_BYTE_VALID_OUT,
    input  wire        RX_FRAME_END_IN,
    input  wire        RX_FRAME_ERROR_IN,
    output reg         RX_FRAME_DROP_OUT,
    output reg         RX_FRAME_KEEP_OUT,
    output wire        RX_MULTI_FRAME_OK_OUT,
    input  wire        TX_LOSS_OF_SYNC_IN,
    input  wire        TX_STALL_CLEAR_IN,
    output reg         BULK_OUT_STALL_OUT,
    output wire        TX_MULTI_FRAME_OUT,
    input  wire [7:0]  MII_SIGNALS_IN,
    input  wire        PHY_INTERRUPT_PIN_IN,
    input  wire [7:0]  GPIO_OUT_IN,
    input  wire [7:0]  GPIO_OE_IN,
    output reg  [7:0]  MII_PIN_OUT,
    output reg  [7:0]  MII_PIN_OE_OUT,
    output reg         PHY_INTERRUPT_PIN_OUT,
    output reg         PHY_INTERRUPT_PIN_OE_OUT,
    input  wire        EE_WAIT_IN,
    output reg         EE_TIMEOUT_OUT,
    input  wire        LITE_RESET_DONE_IN,
    output reg         LITE_RESET_OUT
);

    reg  [1:0]  receive_byte_offset;
    reg         bulk_out_stall_disable;
    reg         mii_pin_visibility;
    reg         discard_errored_frames;
    reg         multi_frame_packing;
    reg         eeprom_timeout_select;
    reg         lite_reset_request;
    reg         phy_choice_strap;
    reg         strap_pending;
    reg  [1:0]  pad_left;
    reg  [18:0] ee_count;
    reg  [7:0]  lite_count;
    wire        wb_req;
    wire        wr_low;
    wire        hit;
    wire [31:0] cfg_word;
    wire        mii_shown;

    assign wb_req = WB_CYC_IN & WB_STB_IN & ~WB_ACK_OUT;
    assign hit    = (WB_ADR_IN == `HWCFG_ADDR_HW_CONFIG);
    assign wr_low = wb_req & WB_WE_IN & hit;

    assign cfg_word = {21'h000000,
                       receive_byte_offset,
                       bulk_out_stall_disable,
                       mii_pin_visibility,
                       discard_errored_frames,
                       multi_frame_packing,
                       eeprom_timeout_select,
                       lite_reset_request,
                       phy_choice_strap,
                       2'h0};

    // one wait-free answer: ack the cycle after the strobe, unmapped reads 0
    always @(posedge SYS_CLK_IN) begin
        if (!RST_N_IN) begin
            WB_ACK_OUT <= 1'b0;
            WB_DAT_OUT <= 32'h00000000;
        end else begin
            WB_ACK_OUT <= wb_req;
            if (wb_req && !WB_WE_IN)
                WB_DAT_OUT <= hit ? cfg_word : 32'h00000000;
        end
    end

    // offset is not guarded: software must hold it once rx runs, see [RULE2]
    always @(posedge SYS_CLK_IN) begin
        if (!RST_N_IN) begin
            receive_byte_offset    <= `HWCFG_RST_RXOFF;
            bulk_out_stall_disable <= `HWCFG_RST_BIT;
            mii_pin_visibility     <= `HWCFG_RST_BIT;
            discard_errored_frames <= `HWCFG_RST_BIT;
            multi_frame_packing    <= `HWCFG_RST_BIT;
            eeprom_timeout_select  <= `HWCFG_RST_BIT;
        end else if (wr_low) begin
            if (WB_SEL_IN[1])
                receive_byte_offset <= WB_DAT_IN[`HWCFG_BIT_RXOFF_HI:
                                                 `HWCFG_BIT_RXOFF_LO];
            if (WB_SEL_IN[1])
                bulk_out_stall_disable <= WB_DAT_IN[`HWCFG_BIT_STALL_DIS];
            if (WB_SEL_IN[0]) begin
                mii_pin_visibility     <= WB_DAT_IN[`HWCFG_BIT_MII_VIS];
                discard_errored_frames <= WB_DAT_IN[`HWCFG_BIT_DISCARD];
                multi_frame_packing    <= WB_DAT_IN[`HWCFG_BIT_MULTI_FRAME];
                eeprom_timeout_select  <= WB_DAT_IN[`HWCFG_BIT_EE_TMO_SEL];
            end
        end
    end

    // strap caught on the first clock after release, never by the reset
    always @(posedge SYS_CLK_IN) begin
        if (!RST_N_IN) begin
            strap_pending    <= 1'b1;
            phy_choice_strap <= 1'b0;
        end else if (strap_pending) begin
            strap_pending    <= 1'b0;
            phy_choice_strap <= PHY_CHOICE_STRAP_IN; // see [RULE15]
        end
    end
    // no write path to phy_choice_strap exists, see [RULE16] [RULE14]

    // lite reset: held until done or the local count ends, see [RULE13]
    always @(posedge SYS_CLK_IN) begin
        if (!RST_N_IN) begin
            lite_reset_request <= 1'b0;
            lite_count         <= 8'h00;
        end else if (!lite_reset_request) begin
            if (wr_low && WB_SEL_IN[0] && WB_DAT_IN[`HWCFG_BIT_LITE_RST]) begin
                lite_reset_request <= 1'b1; // see [RULE11]
                lite_count         <= 8'h00;
            end
        end else if (LITE_RESET_DONE_IN ||
                     lite_count == LITE_RST_CYC[7:0] - 8'h01) begin
            lite_reset_request <= 1'b0; // see [RULE13]
        end else begin
            lite_count <= lite_count + 8'h01;
        end
    end

    // only the datapath sees this reset; usb side has no input here
    always @* begin
        LITE_RESET_OUT = lite_reset_request; // see [RULE12]
    end

    // receive offset: pad bytes of zero before the first data byte
    always @(posedge SYS_CLK_IN) begin
        if (!RST_N_IN) begin
            pad_left          <= 2'h0;
            RX_BYTE_OUT       <= 8'h00;
            RX_BYTE_VALID_OUT <= 1'b0;
        end else if (RX_START_IN) begin
            pad_left          <= receive_byte_offset; // see [RULE1]
            RX_BYTE_OUT       <= 8'h00;
            RX_BYTE_VALID_OUT <= 1'b0;
        end else if (pad_left != 2'h0) begin
            pad_left          <= pad_left - 2'h1; // see [RULE1]
            RX_BYTE_OUT       <= 8'h00;
            RX_BYTE_VALID_OUT <= 1'b1;
        end else begin
            RX_BYTE_OUT       <= RX_BYTE_IN;
            RX_BYTE_VALID_OUT <= RX_BYTE_VALID_IN;
        end
    end

    // frame verdict at frame end
    always @(posedge SYS_CLK_IN) begin
        if (!RST_N_IN) begin
            RX_FRAME_DROP_OUT <= 1'b0;
            RX_FRAME_KEEP_OUT <= 1'b0;
        end else begin
            RX_FRAME_DROP_OUT <= RX_FRAME_END_IN & RX_FRAME_ERROR_IN &
                                 discard_errored_frames; // see [RULE7]
            RX_FRAME_KEEP_OUT <= RX_FRAME_END_IN &
                                 ~(RX_FRAME_ERROR_IN &
                                   discard_errored_frames); // see [RULE7]
        end
    end

    assign RX_MULTI_FRAME_OK_OUT = 1'b1; // see [RULE9]
    assign TX_MULTI_FRAME_OUT    = multi_frame_packing; // see [RULE8]

    // stall held until the transmit side clears it; a new loss wins
    always @(posedge SYS_CLK_IN) begin
        if (!RST_N_IN)
            BULK_OUT_STALL_OUT <= 1'b0;
        else if (TX_LOSS_OF_SYNC_IN && !bulk_out_stall_disable)
            BULK_OUT_STALL_OUT <= 1'b1; // see [RULE3]
        else if (TX_STALL_CLEAR_IN)
            BULK_OUT_STALL_OUT <= 1'b0;
    end

    // mii shown only with internal phy, overriding gpio use
    // one cycle of pin latency traded for glitch-free registered drive
    assign mii_shown = mii_pin_visibility & ~phy_choice_strap; // see [RULE5]

    always @(posedge SYS_CLK_IN) begin
        if (!RST_N_IN) begin
            MII_PIN_OUT              <= 8'h00;
            MII_PIN_OE_OUT           <= 8'h00;
            PHY_INTERRUPT_PIN_OUT    <= 1'b0;
            PHY_INTERRUPT_PIN_OE_OUT <= 1'b0;
        end else if (mii_shown) begin
            MII_PIN_OUT              <= MII_SIGNALS_IN; // see [RULE4]
            MII_PIN_OE_OUT           <= 8'hff; // see [RULE6]
            PHY_INTERRUPT_PIN_OUT    <= PHY_INTERRUPT_PIN_IN;
            PHY_INTERRUPT_PIN_OE_OUT <= 1'b1; // see [RULE4]
        end else if (!phy_choice_strap) begin
            MII_PIN_OUT              <= GPIO_OUT_IN;
            MII_PIN_OE_OUT           <= GPIO_OE_IN;
            PHY_INTERRUPT_PIN_OUT    <= 1'b0;
            PHY_INTERRUPT_PIN_OE_OUT <= 1'b0;
        end else begin
            // external phy owns the mii pins as inputs to this block
            MII_PIN_OUT              <= 8'h00;
            MII_PIN_OE_OUT           <= 8'h00;
            PHY_INTERRUPT_PIN_OUT    <= 1'b0;
            PHY_INTERRUPT_PIN_OE_OUT <= 1'b0;
        end
    end

    // eeprom wait counter; limit chosen by the select bit
    // the long limit is many cycles of real time; benches shrink it
    // by parameter, the counter width covers the documented default
    always @(posedge SYS_CLK_IN) begin
        if (!RST_N_IN) begin
            ee_count       <= 19'h00000;
            EE_TIMEOUT_OUT <= 1'b0;
        end else if (!EE_WAIT_IN) begin
            ee_count       <= 19'h00000;
            EE_TIMEOUT_OUT <= 1'b0;
        end else if (!EE_TIMEOUT_OUT) begin
            ee_count <= ee_count + 19'h00001;
            if (ee_count == (eeprom_timeout_select ?
                             EE_TMO_SHORT_CYC[18:0] - 19'h00001 :
                             EE_TMO_LONG_CYC[18:0] - 19'h00001))
                EE_TIMEOUT_OUT <= 1'b1; // see [RULE10]
        end
    end

endmodule // hwcfg_regs

`default_nettype wire
